// ### psc_host.sv
`timescale 1ns/1ps
module psc_host import psc_pkg::*; #(
    parameter int HALF_CYC = LINK_HALF_CYC,
    parameter int INIT_TIMEOUT = INIT_MAX_CYC,
    parameter int MAX_RETRIES = DEF_MAX_RETRIES
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    psc_link_if.host link,
    input wire logic start_i,
    input wire logic [BYTE_W-1:0] byte_i,
    input wire logic byte_valid_i,
    input wire logic byte_last_i,
    output logic byte_ready_o,
    output logic busy_o,
    output logic done_o,
    output logic error_o,
    output logic rewind_o
);
    function automatic logic reached(input logic [31:0] c, input int lim);
        return c >= 32'(lim - 1);
    endfunction

    psc_host_state_t state_r, state_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [BYTE_W-1:0] sh_r, sh_nxt;
    logic [2:0] pos_r, pos_nxt;
    logic last_r, last_nxt;
    logic [7:0] tries_r, tries_nxt;
    logic [1:0] st_sync_r, ld_sync_r, in_sync_r;
    logic req_n_r, sclk_r, data_r;
    logic ready_r, busy_r, done_r, err_r, rew_r;

    wire st_ok = st_sync_r[1];
    wire ld_ok = ld_sync_r[1];
    wire in_ok = in_sync_r[1];
    wire take = byte_valid_i && ready_r;
    wire in_load = (state_r == H_GAP) || (state_r == H_FETCH)
        || (state_r == H_LOW) || (state_r == H_HIGH)
        || (state_r == H_CHECK) || (state_r == H_POST_LOW)
        || (state_r == H_POST_HIGH);
    wire bit_phase = (state_nxt == H_LOW) || (state_nxt == H_HIGH);
    // divided clock; the divider sets the rate, keep it below the maximum
    wire sclk_nxt = (state_nxt == H_HIGH) || (state_nxt == H_POST_HIGH);
    // fixed low level on data outside bit phases; the clock still toggles in the post-load phases
    wire data_nxt = bit_phase ? sh_nxt[0] : 1'b0;
    wire req_n_nxt = state_nxt != H_REQ_LOW;
    wire ready_nxt = state_nxt == H_FETCH;
    wire busy_nxt = (state_nxt != H_IDLE) && (state_nxt != H_DONE)
        && (state_nxt != H_FAIL);
    wire done_nxt = state_nxt == H_DONE;
    wire err_nxt = state_nxt == H_FAIL;
    wire rew_nxt = (state_r == H_RETRY) && (state_nxt == H_REQ_LOW);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 32'h1;
        sh_nxt = sh_r;
        pos_nxt = pos_r;
        last_nxt = last_r;
        tries_nxt = tries_r;
        case (state_r)
            H_IDLE: begin
                cnt_nxt = 32'h0;
                tries_nxt = 8'h0;
                if (start_i) begin
                    state_nxt = H_REQ_LOW;
                end
            end
            H_REQ_LOW: begin
                if (reached(cnt_r, REQ_LOW_CYC)) begin
                    state_nxt = H_WAIT_ST;
                    cnt_nxt = 32'h0;
                end
            end
            H_WAIT_ST: begin
                if (st_ok) begin
                    state_nxt = H_GAP;
                    cnt_nxt = 32'h0;
                end else if (reached(cnt_r, STATUS_MAX_CYC)) begin
                    state_nxt = H_RETRY;
                end
            end
            H_GAP: begin
                if (reached(cnt_r, ST2CK_CYC)) begin
                    state_nxt = H_FETCH;
                    cnt_nxt = 32'h0;
                end
            end
            H_FETCH: begin
                // waiting for a byte just stretches the clock low
                cnt_nxt = 32'h0;
                if (take) begin
                    sh_nxt = byte_i;
                    last_nxt = byte_last_i;
                    pos_nxt = 3'h0;
                    state_nxt = H_LOW;
                end
            end
            H_LOW: begin
                if (reached(cnt_r, HALF_CYC)) begin
                    state_nxt = H_HIGH;
                    cnt_nxt = 32'h0;
                end
            end
            H_HIGH: begin
                if (reached(cnt_r, HALF_CYC)) begin
                    cnt_nxt = 32'h0;
                    if (pos_r == LAST_BIT_POS) begin
                        state_nxt = last_r ? H_CHECK : H_FETCH;
                    end else begin
                        sh_nxt = sh_r >> 1;
                        pos_nxt = pos_r + 3'h1;
                        state_nxt = H_LOW;
                    end
                end
            end
            H_CHECK: begin
                pos_nxt = 3'h0;
                if (ld_ok) begin
                    state_nxt = H_POST_LOW;
                    cnt_nxt = 32'h0;
                end else if (reached(cnt_r, LOAD_DONE_WAIT_CYC)) begin
                    state_nxt = H_RETRY;
                end
            end
            H_POST_LOW: begin
                if (reached(cnt_r, HALF_CYC)) begin
                    state_nxt = H_POST_HIGH;
                    cnt_nxt = 32'h0;
                end
            end
            H_POST_HIGH: begin
                if (reached(cnt_r, HALF_CYC)) begin
                    cnt_nxt = 32'h0;
                    pos_nxt = pos_r + 3'h1;
                    if (pos_r == 3'(POST_DONE_FALLS - 1)) begin
                        state_nxt = H_WAIT_INIT;
                    end else begin
                        state_nxt = H_POST_LOW;
                    end
                end
            end
            H_WAIT_INIT: begin
                if (in_ok) begin
                    state_nxt = H_DONE;
                end else if (reached(cnt_r, INIT_TIMEOUT)) begin
                    state_nxt = H_RETRY;
                end
            end
            H_DONE, H_FAIL: begin
                cnt_nxt = 32'h0;
                tries_nxt = 8'h0;
                if (start_i) begin
                    state_nxt = H_REQ_LOW;
                end
            end
            H_RETRY: begin
                cnt_nxt = 32'h0;
                if (tries_r >= 8'(MAX_RETRIES)) begin
                    state_nxt = H_FAIL;
                end else begin
                    tries_nxt = tries_r + 8'h1;
                    state_nxt = H_REQ_LOW;
                end
            end
            default: begin
                state_nxt = H_IDLE;
            end
        endcase
        // status pulled low mid-load means a device error
        if (in_load && !st_ok) begin
            state_nxt = H_RETRY;
        end
    end

    always_ff @(posedge clk_i) begin
        st_sync_r <= {st_sync_r[0], link.status};
        ld_sync_r <= {ld_sync_r[0], link.load_done};
        in_sync_r <= {in_sync_r[0], link.init_done};
        if (!reset_n_i) begin
            state_r <= H_IDLE;
            cnt_r <= 32'h0;
            sh_r <= '0;
            pos_r <= 3'h0;
            last_r <= 1'b0;
            tries_r <= 8'h0;
            req_n_r <= 1'b1;
            sclk_r <= 1'b0;
            data_r <= 1'b0;
            ready_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            err_r <= 1'b0;
            rew_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            pos_r <= pos_nxt;
            last_r <= last_nxt;
            tries_r <= tries_nxt;
            req_n_r <= req_n_nxt;
            sclk_r <= sclk_nxt;
            data_r <= data_nxt;
            ready_r <= ready_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            err_r <= err_nxt;
            rew_r <= rew_nxt;
        end
    end

    assign link.config_req_n = req_n_r;
    assign link.cfg_serial_clock = sclk_r;
    assign link.host_data_o = data_r;
    // data is never left floating by the host
    assign link.host_data_oe = 1'b1;
    assign byte_ready_o = ready_r;
    assign busy_o = busy_r;
    assign done_o = done_r;
    assign error_o = err_r;
    assign rewind_o = rew_r;
endmodule

// ### psc_pkg.sv
package psc_pkg;
// Overview of operation
// - host pulls config request low to start
// - after status release, host sends serial bits
// - each byte goes least significant bit first
// - device samples data on serial clock rise
// - clock data until load-complete rises, then initialize
// - two falling edges after load-complete start initialization
// - device releases init-complete, host sees user mode
// - host drives clock and data fixed afterwards
// - device tri-states data pin until user mode
// - host keeps serial clock below maximum rate
// - paused serial clock keeps all loading progress
// - host watches load-complete for errors and end; the host takes mid-load device errors from status instead
// - host restarts when done lines stay low
// - config request low restarts device anytime
// - host holds request low minimum pulse width
// - device error pulls status low until reconfiguration
    localparam int CLK_PERIOD_NS = 8;
    localparam int LINK_PERIOD_NS = 80;
    localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int REQ_LOW_MIN_NS = 500;
    localparam int REQ_LOW_CYC = (REQ_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ST2CK_MIN_NS = 2000;
    localparam int ST2CK_CYC = (ST2CK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STATUS_MAX_NS = 23000;
    localparam int STATUS_MAX_CYC = STATUS_MAX_NS / CLK_PERIOD_NS;
    localparam int INIT_MIN_NS = 300000;
    localparam int INIT_MIN_CYC = (INIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_MAX_NS = 650000;
    localparam int INIT_MAX_CYC = INIT_MAX_NS / CLK_PERIOD_NS;
    localparam int POST_DONE_FALLS = 2;
    localparam int LOAD_DONE_WAIT_CYC = 16;
    localparam int BYTE_W = 8;
    localparam logic [2:0] LAST_BIT_POS = 3'h7;
    localparam int DEF_BITSTREAM_BYTES = 16;
    localparam int DEF_MAX_RETRIES = 3;
    typedef enum logic [2:0] {
        D_RESET, D_STATUS, D_LOAD, D_FALLS, D_INIT, D_USER, D_ERROR
    } psc_dev_state_t;
    typedef enum logic [3:0] {
        H_IDLE, H_REQ_LOW, H_WAIT_ST, H_GAP, H_FETCH, H_LOW, H_HIGH, H_CHECK,
        H_POST_LOW, H_POST_HIGH, H_WAIT_INIT, H_DONE, H_FAIL, H_RETRY
    } psc_host_state_t;
endpackage

// ### psc_link_if.sv
`timescale 1ns/1ps
interface psc_link_if;
    logic config_req_n;
    logic cfg_serial_clock;
    logic host_data_o;
    logic host_data_oe;
    logic dev_data_o;
    logic dev_data_oe;
    logic data;
    logic status_o;
    logic status_oe;
    logic status;
    logic load_done_o;
    logic load_done_oe;
    logic load_done;
    logic init_done_o;
    logic init_done_oe;
    logic init_done;
    // undriven data reads high; open-drain lines have pull-ups
    assign data = host_data_oe ? host_data_o : (dev_data_oe ? dev_data_o : 1'b1);
    assign status = !(status_oe && !status_o);
    assign load_done = !(load_done_oe && !load_done_o);
    assign init_done = !(init_done_oe && !init_done_o);
    modport device (
        input config_req_n, cfg_serial_clock, data,
        output dev_data_o, dev_data_oe, status_o, status_oe,
        output load_done_o, load_done_oe, init_done_o, init_done_oe
    );
    modport host (
        output config_req_n, cfg_serial_clock, host_data_o, host_data_oe,
        input status, load_done, init_done
    );
endinterface

// ### psc_device.sv
`timescale 1ns/1ps
module psc_device import psc_pkg::*; #(
    parameter int BITSTREAM_BYTES = DEF_BITSTREAM_BYTES,
    parameter int STATUS_CYCLES = STATUS_MAX_CYC,
    parameter int INIT_CYCLES = INIT_MIN_CYC
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    psc_link_if.device link,
    input wire logic cfg_error_i,
    input wire logic user_io_en_i,
    input wire logic user_data_i,
    output logic [BYTE_W-1:0] cfg_byte_o,
    output logic cfg_byte_valid_o,
    output logic user_mode_o
);
    // link side: only capture and toggle, so a halted clock loses nothing
    logic bit_r = 1'b0;
    logic rise_tog_r = 1'b0;
    logic fall_tog_r = 1'b0;

    always_ff @(posedge link.cfg_serial_clock) begin
        bit_r <= link.data;
        rise_tog_r <= ~rise_tog_r;
    end

    always_ff @(negedge link.cfg_serial_clock) begin
        fall_tog_r <= ~fall_tog_r;
    end

    psc_dev_state_t state_r, state_nxt;
    logic [2:0] rise_sync_r, fall_sync_r;
    logic [1:0] bit_sync_r, req_sync_r;
    logic rise_ev_d_r;
    logic [31:0] cnt_r, cnt_nxt, bytes_r, bytes_nxt;
    logic [BYTE_W-1:0] sh_r, sh_nxt, byte_r, byte_nxt;
    logic [2:0] pos_r, pos_nxt;
    logic valid_r, valid_nxt;
    logic st_oe_r, ld_oe_r, in_oe_r, user_r, doe_r, dout_r;

    wire req_low = ~req_sync_r[1];
    wire rise_ev = rise_sync_r[2] ^ rise_sync_r[1];
    wire fall_ev = fall_sync_r[2] ^ fall_sync_r[1];
    wire bit_s = bit_sync_r[1];
    wire [BYTE_W-1:0] sh_in = {bit_s, sh_r[BYTE_W-1:1]};
    wire st_oe_nxt = (state_nxt == D_RESET) || (state_nxt == D_STATUS)
        || (state_nxt == D_ERROR);
    wire ld_oe_nxt = st_oe_nxt || (state_nxt == D_LOAD);
    wire user_nxt = state_nxt == D_USER;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 32'h1;
        bytes_nxt = bytes_r;
        sh_nxt = sh_r;
        pos_nxt = pos_r;
        byte_nxt = byte_r;
        valid_nxt = 1'b0;
        case (state_r)
            D_RESET: begin
                cnt_nxt = 32'h0;
                bytes_nxt = 32'h0;
                pos_nxt = 3'h0;
                if (!req_low) begin
                    state_nxt = D_STATUS;
                end
            end
            D_STATUS: begin
                if (cnt_r >= 32'(STATUS_CYCLES - 1)) begin
                    state_nxt = D_LOAD;
                end
            end
            D_LOAD: begin
                cnt_nxt = 32'h0;
                if (cfg_error_i) begin
                    state_nxt = D_ERROR;
                end else if (bytes_r == 32'(BITSTREAM_BYTES)) begin
                    state_nxt = D_FALLS;
                end else if (rise_ev_d_r) begin
                    sh_nxt = sh_in;
                    pos_nxt = pos_r + 3'h1;
                    if (pos_r == LAST_BIT_POS) begin
                        byte_nxt = sh_in;
                        valid_nxt = 1'b1;
                        bytes_nxt = bytes_r + 32'h1;
                    end
                end
            end
            D_FALLS: begin
                cnt_nxt = cnt_r;
                if (fall_ev) begin
                    cnt_nxt = cnt_r + 32'h1;
                    if (cnt_r == 32'(POST_DONE_FALLS - 1)) begin
                        state_nxt = D_INIT;
                        cnt_nxt = 32'h0;
                    end
                end
            end
            D_INIT: begin
                if (cnt_r >= 32'(INIT_CYCLES - 1)) begin
                    state_nxt = D_USER;
                end
            end
            D_USER, D_ERROR: begin
                cnt_nxt = 32'h0;
            end
            default: begin
                state_nxt = D_RESET;
            end
        endcase
        if (req_low) begin
            state_nxt = D_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        rise_sync_r <= {rise_sync_r[1:0], rise_tog_r};
        fall_sync_r <= {fall_sync_r[1:0], fall_tog_r};
        bit_sync_r <= {bit_sync_r[0], bit_r};
        req_sync_r <= {req_sync_r[0], link.config_req_n};
        // bit is stable a whole link period, one cycle late is safe
        rise_ev_d_r <= rise_ev;
        if (!reset_n_i) begin
            state_r <= D_RESET;
            cnt_r <= 32'h0;
            bytes_r <= 32'h0;
            sh_r <= '0;
            pos_r <= 3'h0;
            byte_r <= '0;
            valid_r <= 1'b0;
            st_oe_r <= 1'b1;
            ld_oe_r <= 1'b1;
            in_oe_r <= 1'b1;
            user_r <= 1'b0;
            doe_r <= 1'b0;
            dout_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            bytes_r <= bytes_nxt;
            sh_r <= sh_nxt;
            pos_r <= pos_nxt;
            byte_r <= byte_nxt;
            valid_r <= valid_nxt;
            st_oe_r <= st_oe_nxt;
            ld_oe_r <= ld_oe_nxt;
            in_oe_r <= ~user_nxt;
            user_r <= user_nxt;
            doe_r <= user_nxt && user_io_en_i;
            dout_r <= user_data_i;
        end
    end

    assign link.status_o = 1'b0;
    assign link.status_oe = st_oe_r;
    assign link.load_done_o = 1'b0;
    assign link.load_done_oe = ld_oe_r;
    assign link.init_done_o = 1'b0;
    assign link.init_done_oe = in_oe_r;
    assign link.dev_data_o = dout_r;
    assign link.dev_data_oe = doe_r;
    assign cfg_byte_o = byte_r;
    assign cfg_byte_valid_o = valid_r;
    assign user_mode_o = user_r;
endmodule

// ### psc_props.sv
`timescale 1ns/1ps
module psc_props import psc_pkg::*; #(
    parameter int BITSTREAM_BYTES = DEF_BITSTREAM_BYTES
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic config_req_n,
    input wire logic cfg_serial_clock,
    input wire logic host_data_o,
    input wire logic dev_data_oe,
    input wire logic status,
    input wire logic load_done,
    input wire logic init_done
);
    logic sck_q_r;
    logic [15:0] rise_cnt_r;
    logic [1:0] fall_cnt_r;
    logic [7:0] low_cnt_r;
    wire sck_rise = cfg_serial_clock && !sck_q_r;
    wire sck_fall = !cfg_serial_clock && sck_q_r;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    always_ff @(posedge clk_i) begin
        sck_q_r <= cfg_serial_clock;
    end
    // restarts with every request, so a retry is counted from zero
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !config_req_n) begin
            rise_cnt_r <= 16'h0;
        end else if (sck_rise) begin
            rise_cnt_r <= rise_cnt_r + 16'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !load_done) begin
            fall_cnt_r <= 2'h0;
        end else if (sck_fall && fall_cnt_r != 2'h3) begin
            fall_cnt_r <= fall_cnt_r + 2'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || config_req_n) begin
            low_cnt_r <= 8'h0;
        end else if (low_cnt_r != 8'hff) begin
            low_cnt_r <= low_cnt_r + 8'h1;
        end
    end
    property p_req_clears;
        !config_req_n [*8] |-> !status && !load_done && !init_done;
    endproperty
    a_req_clears: assert property (p_req_clears) else $error("lines high in request");
    property p_req_width;
        $rose(config_req_n) |-> low_cnt_r >= REQ_LOW_CYC;
    endproperty
    a_req_width: assert property (p_req_width) else $error("request pulse short");
    property p_load_exact;
        $rose(load_done) |-> rise_cnt_r == 16'(8 * BITSTREAM_BYTES);
    endproperty
    a_load_exact: assert property (p_load_exact) else $error("load done at wrong count");
    property p_two_falls;
        $rose(init_done) |-> fall_cnt_r >= 2'h2;
    endproperty
    a_two_falls: assert property (p_two_falls) else $error("init before two falls");
    property p_init_after_load;
        $rose(init_done) |-> $past(load_done, 4);
    endproperty
    a_init_after_load: assert property (p_init_after_load) else $error("init without load");
    property p_no_early_drive;
        !init_done |-> !dev_data_oe;
    endproperty
    a_no_early_drive: assert property (p_no_early_drive) else $error("data driven early");
    property p_sck_needs_status;
        $rose(cfg_serial_clock) |-> $past(status, 4);
    endproperty
    a_sck_needs_status: assert property (p_sck_needs_status) else $error("clock w/o status");
    property p_link_quiet;
        init_done && $past(init_done, 4) |-> $stable(cfg_serial_clock) && $stable(host_data_o);
    endproperty
    a_link_quiet: assert property (p_link_quiet) else $error("link moves in user mode");
endmodule

// ### psc_tb_top.sv
`timescale 1ns/1ps
module psc_tb_top import psc_pkg::*;;
    localparam int NB = 4;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic start_i = 1'b0;
    logic [BYTE_W-1:0] byte_i = 8'h00;
    logic byte_valid_i = 1'b0;
    logic byte_last_i = 1'b0;
    logic byte_ready_o, busy_o, done_o, error_o, rewind_o;
    logic cfg_error_i = 1'b0;
    logic b_io_en = 1'b0;
    logic b_user_data = 1'b0;
    logic a_io_en = 1'b0;
    logic b_cfg_error = 1'b0;
    logic [BYTE_W-1:0] cfg_byte_o, cfg_byte_b;
    logic cfg_byte_valid_o, cfg_byte_valid_b, user_mode_o, user_mode_b;
    logic [BYTE_W-1:0] stream [0:NB] = '{8'h02, 8'h1b, 8'hee, 8'h01, 8'h00};
    logic [BYTE_W-1:0] got_a [$];
    logic [BYTE_W-1:0] got_b [$];
    logic wire_bits [$];
    int idx = 0;
    int nidx;
    int n;
    int miscompares = 0;
    int comparisons = 0;
    psc_link_if link();
    psc_link_if link_b();
    always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    psc_host #(.INIT_TIMEOUT(200)) psc_host_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .link(link.host), .start_i(start_i), .byte_i(byte_i), .byte_valid_i(byte_valid_i),
        .byte_last_i(byte_last_i), .byte_ready_o(byte_ready_o), .busy_o(busy_o),
        .done_o(done_o), .error_o(error_o), .rewind_o(rewind_o));
    psc_device #(.BITSTREAM_BYTES(NB), .STATUS_CYCLES(8), .INIT_CYCLES(20)) psc_device_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .link(link.device), .cfg_error_i(cfg_error_i),
        .user_io_en_i(a_io_en), .user_data_i(b_user_data), .cfg_byte_o(cfg_byte_o),
        .cfg_byte_valid_o(cfg_byte_valid_o), .user_mode_o(user_mode_o));
    // second device faces the bench, which plays a host that pauses the clock mid-load
    psc_device #(.BITSTREAM_BYTES(NB), .STATUS_CYCLES(8), .INIT_CYCLES(20)) psc_device_b_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .link(link_b.device), .cfg_error_i(b_cfg_error),
        .user_io_en_i(b_io_en), .user_data_i(b_user_data), .cfg_byte_o(cfg_byte_b),
        .cfg_byte_valid_o(cfg_byte_valid_b), .user_mode_o(user_mode_b));
    psc_props #(.BITSTREAM_BYTES(NB)) psc_props_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .config_req_n(link.config_req_n), .cfg_serial_clock(link.cfg_serial_clock),
        .host_data_o(link.host_data_o), .dev_data_oe(link.dev_data_oe), .status(link.status),
        .load_done(link.load_done), .init_done(link.init_done));
    // byte feeder replays from the first byte on start or retry
    always @(posedge clk_i) begin
        if (start_i || rewind_o) begin
            nidx = 0;
        end else if (byte_valid_i && byte_ready_o) begin
            nidx = idx + 1;
        end else begin
            nidx = idx;
        end
        idx <= nidx;
        byte_i <= stream[nidx];
        byte_last_i <= (nidx == NB - 1);
        byte_valid_i <= (nidx < NB);
    end
    always @(posedge clk_i) begin
        if (rewind_o === 1'b1) got_a.delete();
        if (cfg_byte_valid_o === 1'b1) got_a.push_back(cfg_byte_o);
        if (cfg_byte_valid_b === 1'b1) got_b.push_back(cfg_byte_b);
    end
    always @(posedge link.cfg_serial_clock) wire_bits.push_back(link.data);
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk(what, {7'h0, exp}, {7'h0, got});
    endtask
    task automatic chk_bytes(input string what, ref logic [BYTE_W-1:0] q [$]);
        chk(what, 8'(NB), 8'(q.size()));
        for (int i = 0; i < NB; i++) chk(what, stream[i], q[i]);
    endtask
    task automatic end_of_test();
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic pulse_start();
        @(posedge clk_i);
        start_i <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
    endtask
    task automatic wait_done();
        for (n = 0; n < 3000 && done_o !== 1'b1; n++) @(negedge clk_i);
    endtask
    task automatic t_full_cfg();
        wire_bits.delete();
        pulse_start();
        @(negedge clk_i);
        chk_bit("busy", 1'b1, busy_o);
        chk_bit("req_low", 1'b0, link.config_req_n);
        wait_done();
        chk_bit("done", 1'b1, done_o);
        chk_bit("busy_end", 1'b0, busy_o);
        chk_bit("init_done", 1'b1, link.init_done);
        chk_bit("user_mode", 1'b1, user_mode_o);
        chk_bit("load_done", 1'b1, link.load_done);
        chk_bit("dev_data_oe", 1'b0, link.dev_data_oe);
        chk_bytes("byte", got_a);
        for (int k = 0; k < 8 * NB; k++) chk_bit("wire_bit", stream[k / 8][k % 8], wire_bits[k]);
    endtask
    task automatic t_cfg_error();
        got_a.delete();
        pulse_start();
        for (n = 0; n < 3000 && got_a.size() == 0; n++) @(negedge clk_i);
        @(posedge clk_i);
        cfg_error_i <= 1'b1;
        for (n = 0; n < 20 && link.status !== 1'b0; n++) @(negedge clk_i);
        chk_bit("status_err", 1'b0, link.status);
        for (n = 0; n < 40 && rewind_o !== 1'b1; n++) @(negedge clk_i);
        chk_bit("rewind", 1'b1, rewind_o);
        chk_bit("status_held", 1'b0, link.status);
        @(posedge clk_i);
        cfg_error_i <= 1'b0;
        wait_done();
        chk_bit("done_retry", 1'b1, done_o);
        chk_bit("error", 1'b0, error_o);
        chk_bytes("byte_retry", got_a);
    endtask
    task automatic t_reconfig_user();
        got_a.delete();
        // host wins the resolved pin, so the device drive is only observed
        @(posedge clk_i);
        a_io_en <= 1'b1;
        repeat (2) @(negedge clk_i);
        chk_bit("dev_oe_on", 1'b1, link.dev_data_oe);
        pulse_start();
        repeat (10) @(negedge clk_i);
        chk_bit("user_mode_drop", 1'b0, user_mode_o);
        chk_bit("init_drop", 1'b0, link.init_done);
        chk_bit("dev_oe_drop", 1'b0, link.dev_data_oe);
        @(posedge clk_i);
        a_io_en <= 1'b0;
        wait_done();
        chk_bytes("byte_again", got_a);
    endtask
    // one link bit: low phase carries data, clock is left high afterwards
    // link edges sit 3 ns after a system clock edge, never on one; the link period is ten system clocks
    task automatic b_clock(input logic bit_v);
        #3;
        link_b.cfg_serial_clock <= 1'b0;
        link_b.host_data_o <= bit_v;
        #(LINK_PERIOD_NS / 2);
        link_b.cfg_serial_clock <= 1'b1;
        #(LINK_PERIOD_NS / 2 - 3);
    endtask
    task automatic t_paused_link();
        got_b.delete();
        @(posedge clk_i);
        link_b.config_req_n <= 1'b0;
        repeat (REQ_LOW_CYC) @(posedge clk_i);
        link_b.config_req_n <= 1'b1;
        for (n = 0; n < 100 && link_b.status !== 1'b1; n++) @(negedge clk_i);
        chk_bit("b_status", 1'b1, link_b.status);
        repeat (ST2CK_CYC) @(posedge clk_i);
        for (int i = 0; i < 8 * NB; i++) begin
            b_clock(stream[i / 8][i % 8]);
            if (i == 11) begin
                repeat (1500) @(posedge clk_i);
                chk_bit("b_load_low", 1'b0, link_b.load_done);
            end
        end
        for (n = 0; n < 20 && link_b.load_done !== 1'b1; n++) @(negedge clk_i);
        chk_bit("b_load_done", 1'b1, link_b.load_done);
        b_clock(1'b0);
        repeat (60) @(negedge clk_i);
        chk_bit("b_one_fall", 1'b0, link_b.init_done);
        b_clock(1'b0);
        for (n = 0; n < 80 && link_b.init_done !== 1'b1; n++) @(negedge clk_i);
        chk_bit("b_init_done", 1'b1, link_b.init_done);
        chk_bit("b_user_mode", 1'b1, user_mode_b);
        chk_bytes("b_byte", got_b);
        // host lets go of the pin; undriven reads high, so a low proves the device drives
        @(posedge clk_i);
        link_b.host_data_oe <= 1'b0;
        repeat (4) @(negedge clk_i);
        chk_bit("b_tristate", 1'b0, link_b.dev_data_oe);
        @(posedge clk_i);
        b_io_en <= 1'b1;
        repeat (4) @(negedge clk_i);
        chk_bit("b_user_pin", 1'b0, link_b.data);
    endtask
    initial begin
        link_b.config_req_n = 1'b1;
        link_b.cfg_serial_clock = 1'b0;
        link_b.host_data_o = 1'b0;
        link_b.host_data_oe = 1'b1;
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_full_cfg();
        t_cfg_error();
        t_reconfig_user();
        t_paused_link();
        end_of_test();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        miscompares++;
        end_of_test();
    end
endmodule
